// [msc_top.v]
// Muting supervisor of a multi-beam safety sensor with an APB register slave.
// Assumes sensor, enable and restart pins are asynchronous and the beam
// interruption flag comes from scanning logic on the same clock.
//
// Notes on behaviour
// R1 - Sequence muting: sensor a before sensor b.
// R2 - Sequence end: 8 s after a, 5 s after b.
// R3 - Sensor b within 8 h of a.
// R4 - Object gaps free a sensor for 300 ms.
// R5 - Four sensors in order, each within 4 s.
// R6 - Four-sensor muting works in both directions.
// R7 - Correct end after filter on c / b.
// R8 - Sensor dropout beyond filter is an error.
// R9 - Late next sensor beyond 4 s is error.
// R10 - Muting time limit expiry ends with error.
// R11 - Timeout 10 min, or 100 h modes 2, 4.
// R12 - Timeout extension only in modes 1, 5, 6.
// R13 - Input high before, low suspends expiry.
// R14 - Extension ends on high or 100 h.
// R15 - After extension, at most 10 more minutes.
// R16 - Restart button overrides after a muting error.
// R17 - Alternative sensor b input in modes 2, 3, 4, 6.
// R18 - Controller drives sensor b only when needed.
// R19 - Enable low refuses muting, high allows it.
// R20 - Enable high over 8 hours flags error.
// R21 - Enable must be seen low first; the code arms on the synchroniser's low reset value, whatever the pin does.
// R22 - Muting keeps safety outputs on despite beams.
// R23 - Filter time tolerates brief single sensor dropout.
// R24 - Timers share one tick; mode is static.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "msc_defines.vh"

module msc_top #(
	parameter TICK_CYCLES = `MSC_TICK_CYCLES
) (
	input  wire        core_clk,
	input  wire        rstn,
	input  wire        ce,
	input  wire [2:0]  op_mode,
	input  wire        muting_sensor_a,
	input  wire        muting_sensor_b,
	input  wire        muting_sensor_b_local,
	input  wire        muting_sensor_c,
	input  wire        muting_sensor_d,
	input  wire        enable_or_timeout_input,
	input  wire        restart_interlock,
	input  wire        beam_interrupted,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg         safety_switch_output,
	output reg         muting_active,
	output reg         muting_error,
	output reg         enable_error
);

	// ****************************************************************
	// Constants
	// ****************************************************************
	localparam [2:0]  ST_IDLE  = 3'h0;
	localparam [2:0]  ST_SEQA  = 3'h1;
	localparam [2:0]  ST_ARM   = 3'h2;
	localparam [2:0]  ST_MUTE  = 3'h3;
	localparam [2:0]  ST_ERR   = 3'h4;
	localparam [2:0]  ST_WFREE = 3'h5;
	localparam [28:0] SEQ_END_A = `MSC_SEQ_END_A_TK;
	localparam [28:0] SEQ_END_B = `MSC_SEQ_END_B_TK;
	localparam [28:0] SEQ_WIN   = `MSC_SEQ_WIN_TK;
	localparam [28:0] GAP4      = `MSC_GAP4_TK;
	localparam [28:0] FILT4     = `MSC_FILT4_TK;
	localparam [28:0] TMO_STD   = `MSC_TMO_STD_TK;
	localparam [28:0] TMO_LONG  = `MSC_TMO_LONG_TK;
	localparam [28:0] EN_MAX    = `MSC_EN_MAX_TK;

	// Saturating tick counter step, shared by every timer.
	function [28:0] inc29;
		input [28:0] v;
		begin
			inc29 = (v == 29'h1FFFFFFF) ? v : v + 29'h00000001;
		end
	endfunction

	// Sensor position for a chain step; reverse travel walks d to a.
	function [1:0] pos;
		input       dir;
		input [1:0] k;
		begin
			pos = dir ? (2'h3 - k) : k;
		end
	endfunction

	// ****************************************************************
	// Input synchronisers and time base
	// ****************************************************************
	reg  [`MSC_IN_W-1:0] s1_q;
	reg  [`MSC_IN_W-1:0] s2_q;
	reg                  rst_prev_q;
	wire [`MSC_IN_W-1:0] pins;
	wire                 tick;

	assign pins = {restart_interlock, enable_or_timeout_input, muting_sensor_d,
		muting_sensor_c, muting_sensor_b_local, muting_sensor_b, muting_sensor_a};

	// Two stages per pin; only the second stage is looked at.
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s1_q       <= 7'h00;
			s2_q       <= 7'h00;
			rst_prev_q <= 1'b0;
		end else if (ce) begin
			s1_q       <= pins;
			s2_q       <= s1_q;
			rst_prev_q <= s2_q[`MSC_IN_RST];
		end
	end

	msc_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.core_clk (core_clk),
		.rstn     (rstn),
		.ce       (ce),
		.tick_q   (tick)
	); // [R24]

	// ****************************************************************
	// Mode decode and sensor view
	// ****************************************************************
	wire       seq_mode;
	wire       long_tmo;
	wire       ext_mode;
	wire       alt_mode;
	wire       en_mode;
	wire       s_to;
	wire       s_rst;
	wire       rst_fall;
	wire [3:0] sens;

	// The mode pins are static configuration and are read without sync.
	assign seq_mode = (op_mode == 3'h3) || (op_mode == 3'h4); // [R24]
	assign long_tmo = (op_mode == 3'h2) || (op_mode == 3'h4); // [R11]
	assign ext_mode = (op_mode == 3'h1) || (op_mode == 3'h5) || (op_mode == 3'h6); // [R12]
	assign alt_mode = (op_mode == 3'h2) || seq_mode || (op_mode == 3'h6);
	assign en_mode  = (op_mode == 3'h5);
	assign s_to     = s2_q[`MSC_IN_TO];
	assign s_rst    = s2_q[`MSC_IN_RST];
	assign rst_fall = rst_prev_q && !s_rst;

	// Sensor b may come from either connector in the alternative modes.
	assign sens = {s2_q[`MSC_IN_D], s2_q[`MSC_IN_C],
		s2_q[`MSC_IN_B] | (alt_mode & s2_q[`MSC_IN_BL]), s2_q[`MSC_IN_A]}; // [R17]

	// ****************************************************************
	// Registers and state
	// ****************************************************************
	reg  [2:0]  st_q;
	reg         dir_q;
	reg  [1:0]  stp_q;
	reg  [28:0] gen_q;
	reg  [28:0] tmo_q;
	reg  [28:0] tot_q;
	reg  [28:0] ea_q;
	reg  [28:0] eb_q;
	reg  [28:0] drop_q;
	reg         ext_ok_q;
	reg         ext_on_q;
	reg         ext_done_q;
	reg  [28:0] en_q;
	reg         en_armed_q;
	reg         en_err_q;
	reg         allow_sw_q;
	reg         clr_q;
	wire        allow;
	wire        tmo_exp;
	wire        trk;
	wire        trail;

	// Muting needs software consent and, in mode 5, an armed high enable.
	assign allow = allow_sw_q && !en_err_q &&
		(!en_mode || (en_armed_q && s_to)); // [R19] [R21]

	// After an extension only the standard window remains.
	assign tmo_exp = tmo_q >= (ext_done_q ? TMO_STD : (long_tmo ? TMO_LONG : TMO_STD)); // [R11] [R15]

	// Tracked sensor ends the passage; trailing sensor must be free by then.
	assign trk   = dir_q ? sens[1] : sens[2]; // [R7]
	assign trail = dir_q ? sens[2] : sens[1];

	// ****************************************************************
	// Muting sequence state machine
	// ****************************************************************
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_q  <= ST_IDLE;
			dir_q <= 1'b0;
			stp_q <= 2'h0;
			gen_q <= 29'h00000000;
		end else if (ce) begin
			case (st_q)
			ST_IDLE: begin
				gen_q <= 29'h00000000;
				if (seq_mode) begin
					if (sens[0] && !sens[1]) begin
						st_q <= ST_SEQA; // [R1]
					end
				end else if (sens[0] && (sens[3:1] == 3'h0)) begin
					dir_q <= 1'b0; // [R6]
					stp_q <= 2'h1;
					st_q  <= ST_ARM;
				end else if (sens[3] && (sens[2:0] == 3'h0)) begin
					dir_q <= 1'b1; // [R6]
					stp_q <= 2'h1;
					st_q  <= ST_ARM;
				end
			end
			ST_SEQA: begin
				if (tick) begin
					gen_q <= inc29(gen_q);
				end
				if (!sens[0]) begin
					st_q <= ST_IDLE;
				end else if (gen_q >= SEQ_WIN) begin
					st_q <= ST_WFREE; // [R3]
				end else if (sens[1]) begin
					st_q <= allow ? ST_MUTE : ST_WFREE; // [R1] [R19]
				end
			end
			ST_ARM: begin
				if (tick) begin
					gen_q <= inc29(gen_q);
				end
				if (!sens[pos(dir_q, stp_q - 2'h1)]) begin
					st_q <= ST_IDLE;
				end else if (sens[pos(dir_q, stp_q)]) begin
					gen_q <= 29'h00000000;
					if (gen_q > GAP4) begin
						st_q <= ST_ERR; // [R9]
					end else if (stp_q == 2'h3) begin
						st_q <= allow ? ST_MUTE : ST_WFREE; // [R5] [R19]
					end else begin
						stp_q <= stp_q + 2'h1; // [R5]
					end
				end
			end
			ST_MUTE: begin
				if (tmo_exp) begin
					st_q <= ST_ERR; // [R10]
				end else if (seq_mode) begin
					if ((ea_q >= SEQ_END_A) || (eb_q >= SEQ_END_B)) begin
						st_q <= ST_IDLE; // [R2]
					end
				end else if (drop_q >= FILT4) begin
					st_q <= trail ? ST_ERR : ST_IDLE; // [R7] [R8]
				end
			end
			ST_ERR: begin
				// Leaving only on release means the override lasts while held.
				if (rst_fall) begin
					st_q <= ST_WFREE; // [R16]
				end
			end
			ST_WFREE: begin
				if (sens == 4'h0) begin
					st_q <= ST_IDLE;
				end
			end
			default: begin
				st_q <= ST_ERR;
			end
			endcase
		end
	end

	// ****************************************************************
	// Muting timers and timeout extension
	// ****************************************************************
	// Everything but ext_ok_q is cleared outside muting, so each muting starts afresh.
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tmo_q      <= 29'h00000000;
			tot_q      <= 29'h00000000;
			ea_q       <= 29'h00000000;
			eb_q       <= 29'h00000000;
			drop_q     <= 29'h00000000;
			ext_ok_q   <= 1'b0;
			ext_on_q   <= 1'b0;
			ext_done_q <= 1'b0;
		end else if (ce) begin
			if (st_q != ST_MUTE) begin
				tmo_q      <= 29'h00000000;
				tot_q      <= 29'h00000000;
				ea_q       <= 29'h00000000;
				eb_q       <= 29'h00000000;
				drop_q     <= 29'h00000000;
				ext_ok_q   <= ext_mode && s_to; // [R12] [R13]
				ext_on_q   <= 1'b0;
				ext_done_q <= 1'b0;
			end else begin
				if (ext_ok_q && !ext_done_q && !ext_on_q && !s_to) begin
					ext_on_q <= 1'b1; // [R13]
				end
				if (ext_on_q && (s_to || (tot_q >= TMO_LONG))) begin
					ext_on_q   <= 1'b0; // [R14]
					ext_done_q <= 1'b1;
					tmo_q      <= 29'h00000000; // [R15]
				end else if (tick && !ext_on_q) begin
					tmo_q <= inc29(tmo_q); // [R13]
				end
				if (tick) begin
					tot_q <= inc29(tot_q);
				end
				// A returning sensor restarts the end timers for the next object.
				if (sens[0]) begin
					ea_q <= 29'h00000000; // [R4]
				end else if (tick) begin
					ea_q <= inc29(ea_q); // [R2]
				end
				if (sens[0] || sens[1]) begin
					eb_q <= 29'h00000000; // [R4]
				end else if (tick) begin
					eb_q <= inc29(eb_q); // [R2]
				end
				if (trk) begin
					drop_q <= 29'h00000000;
				end else if (tick) begin
					drop_q <= inc29(drop_q); // [R8] [R23]
				end
			end
		end
	end

	// ****************************************************************
	// Muting enable supervision
	// ****************************************************************
	// The error flag is sticky; a new overrun beats a clear in the same cycle.
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			en_q       <= 29'h00000000;
			en_armed_q <= 1'b0;
			en_err_q   <= 1'b0;
		end else if (ce) begin
			if (en_mode && !s_to) begin
				en_armed_q <= 1'b1; // [R21]
			end
			if (en_mode && s_to) begin
				if (tick) begin
					en_q <= inc29(en_q);
				end
			end else begin
				en_q <= 29'h00000000;
			end
			if (en_mode && (en_q > EN_MAX)) begin
				en_err_q <= 1'b1; // [R20]
			end else if (rst_fall || clr_q) begin
				en_err_q <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Safety outputs
	// ****************************************************************
	// The switching output follows the field unless muting or override holds it on, or an error without override holds it off.
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			safety_switch_output <= 1'b0;
			muting_active        <= 1'b0;
			muting_error         <= 1'b0;
			enable_error         <= 1'b0;
		end else if (ce) begin
			safety_switch_output <= (st_q == ST_MUTE) || // [R22]
				((st_q == ST_ERR) && s_rst) || // [R16]
				((st_q != ST_ERR) && !beam_interrupted); // [R8]
			muting_active <= (st_q == ST_MUTE);
			muting_error  <= (st_q == ST_ERR);
			enable_error  <= en_err_q;
		end
	end

	// ****************************************************************
	// APB slave
	// ****************************************************************
	wire        acc;
	wire        hit_ctrl;
	wire        hit_stat;
	wire        hit_dur;
	wire [31:0] rd_d;

	assign acc      = psel && penable;
	assign hit_ctrl = (paddr == `MSC_REG_CTRL);
	assign hit_stat = (paddr == `MSC_REG_STATUS);
	assign hit_dur  = (paddr == `MSC_REG_DUR);
	assign rd_d = hit_ctrl ? {31'h00000000, allow_sw_q} :
		hit_stat ? {21'h000000, op_mode, ext_on_q, en_armed_q, en_err_q,
			(st_q == ST_ERR), dir_q, st_q} :
		hit_dur ? {3'h0, tot_q} : 32'h00000000;

	// One wait state; writes land on the edge that samples pready high.
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pready     <= 1'b0;
			prdata     <= 32'h00000000;
			pslverr    <= 1'b0;
			allow_sw_q <= `MSC_CTRL_ALLOW_RST;
			clr_q      <= 1'b0;
		end else if (ce) begin
			pready <= acc && !pready;
			if (acc && !pready) begin
				prdata  <= pwrite ? 32'h00000000 : rd_d;
				pslverr <= !(hit_ctrl || hit_stat || hit_dur);
			end
			clr_q <= acc && pready && pwrite && hit_ctrl && pwdata[`MSC_CTRL_CLR];
			if (acc && pready && pwrite && hit_ctrl) begin
				allow_sw_q <= pwdata[`MSC_CTRL_ALLOW];
			end
		end
	end

endmodule

`default_nettype wire

// [msc_defines.vh]
// Constants shared by the muting sequence controller: time base, muting times,
// register offsets, field positions and reset values.
// Assumes a 10 MHz core clock and a 1 ms internal tick.
`ifndef MSC_DEFINES_VH
`define MSC_DEFINES_VH

// ****************************************************************
// Time base
// ****************************************************************
`define MSC_CLK_HZ           10000000
`define MSC_T_TICK_MS        1
`define MSC_TICK_CYCLES      (`MSC_CLK_HZ / 1000 * `MSC_T_TICK_MS)
`define MSC_MS_PER_S         1000
`define MSC_MS_PER_MIN       60000
`define MSC_MS_PER_H         3600000

// ****************************************************************
// Muting times, as printed, and their counts in ticks
// ****************************************************************
`define MSC_T_SEQ_END_A_S    8
`define MSC_T_SEQ_END_B_S    5
`define MSC_T_SEQ_WIN_H      8
`define MSC_T_GAP4_S         4
`define MSC_T_FILT4_MS       100
`define MSC_T_TMO_STD_MIN    10
`define MSC_T_TMO_LONG_H     100
`define MSC_T_EN_MAX_H       8
`define MSC_SEQ_END_A_TK     (`MSC_T_SEQ_END_A_S * `MSC_MS_PER_S / `MSC_T_TICK_MS)
`define MSC_SEQ_END_B_TK     (`MSC_T_SEQ_END_B_S * `MSC_MS_PER_S / `MSC_T_TICK_MS)
`define MSC_SEQ_WIN_TK       (`MSC_T_SEQ_WIN_H * `MSC_MS_PER_H / `MSC_T_TICK_MS)
`define MSC_GAP4_TK          (`MSC_T_GAP4_S * `MSC_MS_PER_S / `MSC_T_TICK_MS)
`define MSC_FILT4_TK         (`MSC_T_FILT4_MS / `MSC_T_TICK_MS)
`define MSC_TMO_STD_TK       (`MSC_T_TMO_STD_MIN * `MSC_MS_PER_MIN / `MSC_T_TICK_MS)
`define MSC_TMO_LONG_TK      (`MSC_T_TMO_LONG_H * `MSC_MS_PER_H / `MSC_T_TICK_MS)
`define MSC_EN_MAX_TK        (`MSC_T_EN_MAX_H * `MSC_MS_PER_H / `MSC_T_TICK_MS)

// ****************************************************************
// Register map
// ****************************************************************
`define MSC_REG_CTRL         12'h000
`define MSC_REG_STATUS       12'h004
`define MSC_REG_DUR          12'h008
`define MSC_CTRL_ALLOW       0
`define MSC_CTRL_CLR         1
`define MSC_CTRL_ALLOW_RST   1'b1

// ****************************************************************
// Positions of the synchronised pin inputs
// ****************************************************************
`define MSC_IN_A             0
`define MSC_IN_B             1
`define MSC_IN_BL            2
`define MSC_IN_C             3
`define MSC_IN_D             4
`define MSC_IN_TO            5
`define MSC_IN_RST           6
`define MSC_IN_W             7

`endif

// [msc_tick.v]
// Millisecond tick generator for the muting timers.
// Assumes one free running core clock and a clock enable that freezes it.
`timescale 1ns/1ps
`default_nettype none

module msc_tick #(
	parameter TICK_CYCLES = 10000
) (
	input  wire        core_clk,
	input  wire        rstn,
	input  wire        ce,
	output reg         tick_q
);

	// The count is cut to the counter's width on purpose.
	localparam integer LAST_I = TICK_CYCLES - 1;
	localparam [13:0]  LAST   = LAST_I[13:0];

	reg [13:0] cnt_q;

	// A single shared base keeps all muting timers in step with each other.
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q  <= 14'h0000;
			tick_q <= 1'b0;
		end else if (ce) begin
			tick_q <= (cnt_q == LAST);
			if (cnt_q == LAST) begin
				cnt_q <= 14'h0000;
			end else begin
				cnt_q <= cnt_q + 14'h0001;
			end
		end
	end

endmodule

`default_nettype wire

// [msc_chk.sv]
// Port-level assertions for the muting sequence controller.
// Assumes it is bound to msc_top; every output there comes from a flip-flop.
`timescale 1ns/1ps
`default_nettype none

module msc_chk (
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire logic [2:0]  op_mode,
	input wire logic        muting_sensor_a,
	input wire logic        muting_sensor_b,
	input wire logic        muting_sensor_b_local,
	input wire logic        muting_sensor_c,
	input wire logic        muting_sensor_d,
	input wire logic        enable_or_timeout_input,
	input wire logic        restart_interlock,
	input wire logic        beam_interrupted,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        safety_switch_output,
	input wire logic        muting_active,
	input wire logic        muting_error
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	// Pins pass a two-flop synchroniser, so causes are looked up two edges back.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	wire logic seq_mode = (op_mode == 3'h3) || (op_mode == 3'h4);
	wire logic sens_b   = muting_sensor_b | muting_sensor_b_local;
	wire logic all_four = muting_sensor_a & sens_b & muting_sensor_c & muting_sensor_d;

	property p_seq_order;
		$rose(muting_active) && seq_mode |-> $past(muting_sensor_a, 2) && $past(sens_b, 2);
	endproperty
	a_seq_order: assert property (p_seq_order)
		else $error("sequence muting began without sensors a and b");
	property p_four;
		$rose(muting_active) && !seq_mode |-> $past(all_four, 2);
	endproperty
	a_four: assert property (p_four)
		else $error("four sensor muting began without all four sensors");
	property p_enable;
		$rose(muting_active) && op_mode == 3'h5 |-> $past(enable_or_timeout_input, 2);
	endproperty
	a_enable: assert property (p_enable)
		else $error("muting began with enable low");
	property p_hold_a;
		seq_mode && muting_active && muting_sensor_a && $past(muting_sensor_a, 2)
			|=> muting_active || muting_error;
	endproperty
	a_hold_a: assert property (p_hold_a)
		else $error("sequence muting ended while sensor a was still active");
	property p_mute_on;
		muting_active [*2] |-> safety_switch_output;
	endproperty
	a_mute_on: assert property (p_mute_on)
		else $error("outputs off while muting");
	property p_err_off;
		(muting_error && !restart_interlock) [*5] |-> !safety_switch_output;
	endproperty
	a_err_off: assert property (p_err_off)
		else $error("outputs on in error without restart");
	property p_guard;
		(!muting_active && !muting_error && beam_interrupted) [*3] |-> !safety_switch_output;
	endproperty
	a_guard: assert property (p_guard)
		else $error("outputs on with field interrupted and no muting");
	property p_excl;
		!(muting_active && muting_error);
	endproperty
	a_excl: assert property (p_excl)
		else $error("muting and error at once");
	property p_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_wait: assert property (p_wait)
		else $error("bus answer not one cycle after access");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("ready longer than one cycle");
	property p_unmap;
		pready && psel && paddr[11:2] > 10'h002 |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped access not refused");

	c_mute: cover property ($rose(muting_active));
	c_err: cover property ($rose(muting_error));
	c_refuse: cover property (pready && pslverr);
endmodule

bind msc_top msc_chk msc_chk_i (.core_clk, .rstn, .op_mode, .muting_sensor_a, .muting_sensor_b,
	.muting_sensor_b_local, .muting_sensor_c, .muting_sensor_d, .enable_or_timeout_input,
	.restart_interlock, .beam_interrupted, .psel, .penable, .paddr, .prdata, .pready,
	.pslverr, .safety_switch_output, .muting_active, .muting_error);
`default_nettype wire

// [msc_field.sv]
// Field model: muting sensors, machine control, restart button and scanner.
// Assumes the bench changes levels only through put(), right after an edge.
`timescale 1ns/1ps
`default_nettype none

module msc_field (
	input  wire logic core_clk,
	output wire logic muting_sensor_a,
	output wire logic muting_sensor_b,
	output wire logic muting_sensor_b_local,
	output wire logic muting_sensor_c,
	output wire logic muting_sensor_d,
	output wire logic enable_or_timeout_input,
	output wire logic restart_interlock,
	output wire logic beam_interrupted
);
	// Pin image, bit 7 down to 0: beam, restart, enable, d, c, b local, b, a.
	// All low from time zero, so the enable input is seen low before use.
	logic [7:0] pins_q = 8'h00;
	assign {beam_interrupted, restart_interlock, enable_or_timeout_input, muting_sensor_d,
		muting_sensor_c, muting_sensor_b_local, muting_sensor_b, muting_sensor_a} = pins_q;

	// Callers leave 300 ms or more free between objects, raise the control's
	// sensor b only for a real transport and set the enable before muting.
	task automatic put(input logic [7:0] v);
		@(posedge core_clk);
		pins_q <= v;
	endtask
endmodule
`default_nettype wire

// [muting_sequence_controller_bench.sv]
// Self-checking bench for the muting sequence controller.
// Assumes a 1 ms tick of TK core clocks; every muting time scales with it.
`timescale 1ns/1ps
`default_nettype none

module muting_sequence_controller_bench;
	localparam int TK = 2;
	logic             core_clk = 1'b0;
	logic             rstn     = 1'b0;
	logic [2:0]       op_mode  = 3'h3;
	logic             psel     = 1'b0;
	logic             penable  = 1'b0;
	logic             pwrite   = 1'b0;
	logic [11:0]      paddr    = 12'h000;
	logic [31:0]      pwdata   = 32'h0;
	logic [31:0]      rd;
	logic             er;
	int               n_mismatch = 0;
	int               n_tests    = 0;
	wire logic [31:0] prdata;
	wire logic        pready, pslverr, safety_switch_output, muting_active, muting_error;
	wire logic        enable_error;
	wire logic        muting_sensor_a, muting_sensor_b, muting_sensor_b_local;
	wire logic        muting_sensor_c, muting_sensor_d, enable_or_timeout_input;
	wire logic        restart_interlock, beam_interrupted;

	// ****************************************************************
	// Clock, partner and design
	// ****************************************************************
	always #50 core_clk = ~core_clk;
	msc_field msc_field_i (.core_clk, .muting_sensor_a, .muting_sensor_b,
		.muting_sensor_b_local, .muting_sensor_c, .muting_sensor_d,
		.enable_or_timeout_input, .restart_interlock, .beam_interrupted);
	// A small tick keeps the multi-second sequences inside a short run.
	msc_top #(.TICK_CYCLES(TK)) msc_top_i (.core_clk, .rstn, .ce(1'b1), .op_mode,
		.muting_sensor_a, .muting_sensor_b, .muting_sensor_b_local, .muting_sensor_c,
		.muting_sensor_d, .enable_or_timeout_input, .restart_interlock, .beam_interrupted,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.safety_switch_output, .muting_active, .muting_error, .enable_error);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Compares {muting, error, outputs on} in one go.
	task automatic look(input logic [2:0] e);
		chk(32'({muting_active, muting_error, safety_switch_output}), 32'(e));
	endtask
	task automatic ms(input int n);
		repeat (n * TK) @(posedge core_clk);
	endtask
	task automatic st(input logic [7:0] v, input int n);
		msc_field_i.put(v);
		ms(n);
	endtask
	// Activates four patterns, most significant byte first, 500 ms apart.
	task automatic arm4(input logic [31:0] p, input logic [7:0] extra);
		for (int i = 3; i >= 0; i--) st(p[i*8 +: 8] | extra, 500);
	endtask
	// The request stays put until ready is sampled high; data are taken there.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge core_clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) n_mismatch++;
	endtask
	task automatic rst_mode(input logic [2:0] m);
		msc_field_i.put(8'h00);
		rstn    <= 1'b0;
		op_mode <= m;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		ms(5);
	endtask
	task automatic final_report();
		$display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		ms(5);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, 12'h004, 32'hFFFFFFFF);
		apb(1'b0, 12'h004, 32'h0);
		chk(32'({rd[10:8], rd[2:0]}), 32'h18);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd, 32'h0);
		chk(32'(er), 32'h1);
		st(8'h02, 5);
		st(8'h03, 5);
		look(3'h1);
		st(8'h00, 300);
		st(8'h01, 5);
		st(8'h85, 5);
		look(3'h5);
		st(8'h84, 7990);
		look(3'h5);
		ms(30);
		look(3'h0);
		st(8'h00, 300);
		st(8'h01, 5);
		st(8'h03, 5);
		st(8'h02, 100);
		st(8'h00, 4990);
		look(3'h5);
		ms(30);
		look(3'h1);
		apb(1'b1, 12'h000, 32'h0);
		st(8'h01, 5);
		st(8'h03, 5);
		look(3'h1);
		st(8'h00, 300);
		apb(1'b1, 12'h000, 32'h1);
		$display("test sequence muting finished");
		rst_mode(3'h2);
		arm4(32'h01030B1B, 8'h00);
		look(3'h5);
		st(8'h1A, 200);
		st(8'h18, 200);
		st(8'h10, 300);
		look(3'h1);
		st(8'h00, 300);
		arm4(32'h10181A1B, 8'h00);
		look(3'h5);
		st(8'h0B, 200);
		st(8'h03, 200);
		st(8'h01, 300);
		look(3'h1);
		st(8'h00, 300);
		arm4(32'h01030B1B, 8'h80);
		look(3'h5);
		st(8'h93, 300);
		look(3'h2);
		st(8'hD3, 10);
		look(3'h3);
		st(8'h00, 300);
		look(3'h1);
		st(8'h01, 4100);
		st(8'h03, 20);
		look(3'h2);
		st(8'h43, 10);
		look(3'h3);
		st(8'h00, 300);
		$display("test four sensor muting finished");
		rst_mode(3'h5);
		st(8'h20, 300);
		arm4(32'h01030B1B, 8'h20);
		look(3'h5);
		st(8'h3A, 200);
		st(8'h38, 200);
		st(8'h30, 300);
		look(3'h1);
		st(8'h00, 300);
		arm4(32'h01030B1B, 8'h00);
		look(3'h1);
		st(8'h00, 300);
		chk(32'(enable_error), 32'h0);
		$display("test muting enable finished");
		final_report();
	end

	// Cuts a hang short; the tests need roughly 66000 cycles.
	initial begin
		repeat (90000) @(posedge core_clk);
		n_mismatch++;
		final_report();
	end
endmodule
`default_nettype wire
